// *** src/csb_pkg.sv ***
package csb_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SETUP_TIME_NS = 4000;
  localparam int unsigned SETUP_CYCLES = (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;

  localparam int unsigned CS_BYTES_PER_CHAN = 5;
  localparam int unsigned CS_BYTES = 10;
  localparam int unsigned CS_BITS_PER_CHAN = 40;
  localparam int unsigned BIT_IDX_W = 6;

  localparam logic [7:0] ADDR_RX_DATA_CTRL = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_RX_STATUS = 8'h16;
  localparam logic [7:0] ADDR_CS_FIRST = 8'h23;
  localparam logic [7:0] ADDR_CS_LAST = 8'h2c;
  localparam logic [7:0] ADDR_BURST_INFO0 = 8'h2d;
  localparam logic [7:0] ADDR_BURST_INFO1 = 8'h2e;
  localparam logic [7:0] ADDR_BURST_LEN0 = 8'h2f;
  localparam logic [7:0] ADDR_BURST_LEN1 = 8'h30;

  localparam int unsigned INHIBIT_BIT = 2;
  localparam int unsigned XFER_IRQ_EN_BIT = 0;
  localparam int unsigned UPDATE_ON_ERR_BIT = 7;
  localparam int unsigned RATE_LSB = 5;
  localparam int unsigned LOCK_BIT = 4;

  localparam logic [7:0] RX_DATA_CTRL_RESET = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic UPDATE_ON_ERR_RESET = 1'b0;
  localparam logic [1:0] RATE_RESET = 2'h0;
endpackage

// *** src/csb_fifo2.sv ***
module csb_fifo2 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  logic [1:0][WIDTH-1:0] mem_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic wr_ptr_q;
  logic rd_ptr_q;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  assign o_in_ready = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_data = mem_q[rd_ptr_q];
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mem_q <= '0;
      cnt_q <= 2'h0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wr_ptr_q] <= i_in_data;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop)
      begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      cnt_q <= cnt_d;
    end
  end
endmodule

// *** src/csb_mem.sv ***
module csb_mem #(
  parameter int unsigned WORDS = 10,
  parameter int unsigned AW = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_load,
  input wire logic [WORDS-1:0][7:0] i_load_data,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data
);
  logic [WORDS-1:0][7:0] mem_q;

  // The whole block is loaded in one edge so a host read never sees a half-copied block.
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mem_q <= '0;
      o_rd_data <= 8'h00;
    end
    else
    begin
      if (i_load)
      begin
        mem_q <= i_load_data;
      end
      o_rd_data <= (i_rd_addr < AW'(WORDS)) ? mem_q[i_rd_addr] : 8'h00;
    end
  end
endmodule

// *** src/csb_channel_status_buffer.sv ***
module csb_channel_status_buffer #(
  parameter int unsigned SETUP_CYCLES = csb_pkg::SETUP_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_master_slave_strap_pin,
  input wire logic i_output_format_strap_pin,
  input wire logic i_cs_valid,
  output logic o_cs_ready,
  input wire logic i_cs_bit,
  input wire logic i_cs_chan_b,
  input wire logic i_block_start,
  input wire logic i_pll_lock,
  input wire logic i_err_biphase,
  input wire logic i_err_confidence,
  input wire logic i_err_parity,
  input wire logic i_err_crc,
  input wire logic [1:0] i_received_rate_field,
  input wire logic i_burst_valid,
  input wire logic [15:0] i_burst_info_word,
  input wire logic [15:0] i_burst_length_word,
  input wire logic i_output_frame_clock,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_running,
  output logic o_mode_master,
  output logic o_mode_format,
  output logic o_general_output_pin,
  output logic o_general_output_pin_oe,
  output logic o_xfer_irq,
  output logic [1:0] o_received_rate_field
);
  typedef enum logic [1:0] {CSB_ST_SENSE, CSB_ST_SETUP, CSB_ST_RUN} csb_state_t;

  localparam logic [csb_pkg::CNT_W-1:0] SETUP_LAST = csb_pkg::CNT_W'(SETUP_CYCLES - 1);

  csb_state_t state_q;
  csb_state_t state_d;
  logic [csb_pkg::CNT_W-1:0] cnt_q;
  logic mode_master_q;
  logic mode_format_q;

  // Start-up: straps are caught by a clocked process after release, never by the reset.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      CSB_ST_SENSE: state_d = CSB_ST_SETUP;
      CSB_ST_SETUP: state_d = (cnt_q == SETUP_LAST) ? CSB_ST_RUN : CSB_ST_SETUP;
      CSB_ST_RUN: state_d = CSB_ST_RUN;
      default: state_d = CSB_ST_SENSE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q <= CSB_ST_SENSE;
      cnt_q <= '0;
      mode_master_q <= 1'b0;
      mode_format_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == CSB_ST_SENSE)
      begin
        mode_master_q <= i_master_slave_strap_pin;
        mode_format_q <= i_output_format_strap_pin;
      end
      if (state_q == CSB_ST_SETUP)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  wire running = (state_q == CSB_ST_RUN);
  assign o_running = running;
  assign o_mode_master = mode_master_q;
  assign o_mode_format = mode_format_q;

  logic [7:0] rx_data_ctrl_q;
  logic [7:0] irq_enable_q;
  logic update_on_err_q;
  wire wr_ctrl = i_reg_wr && (i_reg_addr == csb_pkg::ADDR_RX_DATA_CTRL);
  wire wr_irq = i_reg_wr && (i_reg_addr == csb_pkg::ADDR_IRQ_ENABLE);
  wire wr_status = i_reg_wr && (i_reg_addr == csb_pkg::ADDR_RX_STATUS);
  wire inhibit = rx_data_ctrl_q[csb_pkg::INHIBIT_BIT];
  wire xfer_irq_en = irq_enable_q[csb_pkg::XFER_IRQ_EN_BIT];

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rx_data_ctrl_q <= csb_pkg::RX_DATA_CTRL_RESET;
      irq_enable_q <= csb_pkg::IRQ_ENABLE_RESET;
      update_on_err_q <= csb_pkg::UPDATE_ON_ERR_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        rx_data_ctrl_q <= i_reg_wdata;
      end
      if (wr_irq)
      begin
        irq_enable_q <= i_reg_wdata;
      end
      if (wr_status)
      begin
        update_on_err_q <= i_reg_wdata[csb_pkg::UPDATE_ON_ERR_BIT];
      end
    end
  end

  // Staging buffer fed by the receiver, one bit counter per channel.
  logic [csb_pkg::CS_BYTES-1:0][7:0] stage_q;
  logic [csb_pkg::BIT_IDX_W-1:0] idx_a_q;
  logic [csb_pkg::BIT_IDX_W-1:0] idx_b_q;
  logic [3:0] blk_err_q;
  wire cs_take = i_cs_valid && o_cs_ready;
  wire [csb_pkg::BIT_IDX_W-1:0] cur_idx = i_cs_chan_b ? idx_b_q : idx_a_q;
  wire in_window = (cur_idx < csb_pkg::BIT_IDX_W'(csb_pkg::CS_BITS_PER_CHAN));
  wire [3:0] byte_sel = 4'(cur_idx[5:3]) + (i_cs_chan_b ? 4'(csb_pkg::CS_BYTES_PER_CHAN) : 4'h0);
  wire [2:0] bit_sel = 3'h7 - cur_idx[2:0];
  wire [3:0] err_now = {i_err_crc, i_err_biphase, i_err_confidence, i_err_parity};
  wire blk_err_any = |blk_err_q;

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      stage_q <= '0;
      idx_a_q <= '0;
      idx_b_q <= '0;
      blk_err_q <= 4'h0;
    end
    else if (running)
    begin
      if (i_block_start)
      begin
        idx_a_q <= '0;
        idx_b_q <= '0;
        // An error seen on the boundary edge belongs to the new block and is not lost.
        blk_err_q <= err_now;
      end
      else
      begin
        blk_err_q <= blk_err_q | err_now;
        if (cs_take && in_window)
        begin
          stage_q[byte_sel][bit_sel] <= i_cs_bit;
          if (i_cs_chan_b)
          begin
            idx_b_q <= idx_b_q + 1'b1;
          end
          else
          begin
            idx_a_q <= idx_a_q + 1'b1;
          end
        end
      end
    end
  end

  // Copy decision made once per block boundary, so transfers are at least one block apart.
  wire err_blocks = update_on_err_q && blk_err_any;
  wire xfer = running && i_block_start && i_pll_lock && !err_blocks && !inhibit;
  wire rate_refresh = running && i_block_start && !err_blocks;

  logic [1:0] rate_q;
  logic xfer_irq_q;
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rate_q <= csb_pkg::RATE_RESET;
      xfer_irq_q <= 1'b0;
    end
    else
    begin
      if (rate_refresh)
      begin
        rate_q <= i_received_rate_field;
      end
      xfer_irq_q <= xfer && xfer_irq_en;
    end
  end
  assign o_received_rate_field = rate_q;
  assign o_xfer_irq = xfer_irq_q;

  wire cs_sel = (i_reg_addr >= csb_pkg::ADDR_CS_FIRST) && (i_reg_addr <= csb_pkg::ADDR_CS_LAST);
  wire [7:0] cs_offset = i_reg_addr - csb_pkg::ADDR_CS_FIRST;
  logic [7:0] mem_rdata;

  csb_mem #(
    .WORDS(csb_pkg::CS_BYTES),
    .AW(4)
  ) u_visible (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_load(xfer),
    .i_load_data(stage_q),
    .i_rd_addr(cs_offset[3:0]),
    .o_rd_data(mem_rdata)
  );

  logic [15:0] burst_info_q;
  logic [15:0] burst_len_q;
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      burst_info_q <= 16'h0000;
      burst_len_q <= 16'h0000;
    end
    else if (running && i_burst_valid)
    begin
      burst_info_q <= i_burst_info_word;
      burst_len_q <= i_burst_length_word;
    end
  end

  // Register reads answer one cycle after the strobe; unmapped offsets read zero.
  wire [7:0] status_byte = {update_on_err_q, rate_q, i_pll_lock, blk_err_q};
  wire [7:0] direct_rdata =
    (i_reg_addr == csb_pkg::ADDR_RX_DATA_CTRL) ? rx_data_ctrl_q :
    (i_reg_addr == csb_pkg::ADDR_IRQ_ENABLE) ? irq_enable_q :
    (i_reg_addr == csb_pkg::ADDR_RX_STATUS) ? status_byte :
    (i_reg_addr == csb_pkg::ADDR_BURST_INFO0) ? burst_info_q[7:0] :
    (i_reg_addr == csb_pkg::ADDR_BURST_INFO1) ? burst_info_q[15:8] :
    (i_reg_addr == csb_pkg::ADDR_BURST_LEN0) ? burst_len_q[7:0] :
    (i_reg_addr == csb_pkg::ADDR_BURST_LEN1) ? burst_len_q[15:8] : 8'h00;

  logic rvalid_q;
  logic rd_from_mem_q;
  logic [7:0] direct_q;
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rvalid_q <= 1'b0;
      rd_from_mem_q <= 1'b0;
      direct_q <= 8'h00;
    end
    else
    begin
      rvalid_q <= i_reg_rd;
      rd_from_mem_q <= cs_sel;
      direct_q <= direct_rdata;
    end
  end
  assign o_reg_rvalid = rvalid_q;
  assign o_reg_rdata = rd_from_mem_q ? mem_rdata : direct_q;

  // Serial C output: each frame clock edge presents the next buffered bit.
  logic frame_q;
  logic gpo_q;
  logic fifo_valid;
  logic fifo_bit;
  logic fifo_in_ready;
  wire frame_edge = running && (i_output_frame_clock != frame_q);

  csb_fifo2 #(
    .WIDTH(1)
  ) u_cbuf (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_in_valid(i_cs_valid && running),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_cs_bit),
    .o_out_valid(fifo_valid),
    .i_out_ready(frame_edge),
    .o_out_data(fifo_bit)
  );
  // The empty buffer would report room during reset, so ready is held off until running.
  assign o_cs_ready = running && fifo_in_ready;

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      frame_q <= 1'b0;
      gpo_q <= 1'b0;
    end
    else
    begin
      frame_q <= i_output_frame_clock;
      if (frame_edge && fifo_valid)
      begin
        gpo_q <= fifo_bit;
      end
    end
  end
  assign o_general_output_pin = gpo_q;
  assign o_general_output_pin_oe = running;
endmodule

// *** dv/csb_checker.sv ***
module csb_checker #(
  parameter int unsigned SETUP_CYCLES = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_block_start,
  input wire logic i_pll_lock,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic o_running,
  input wire logic o_cs_ready,
  input wire logic o_general_output_pin_oe,
  input wire logic o_xfer_irq,
  input wire logic [1:0] o_received_rate_field
);
  logic [15:0] up_q;
  // Saturates so a long run never wraps into a false start-up match.
  always_ff @(posedge i_sys_clk or negedge i_rstn)
    if (!i_rstn)
      up_q <= 16'h0;
    else if (up_q != 16'hffff)
      up_q <= up_q + 16'h1;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  reset_quiet_a: assert property (disable iff (1'b0) !i_rstn |->
    !o_running && !o_cs_ready && !o_xfer_irq && !o_general_output_pin_oe)
    else $error("output active in reset");
  run_delay_a: assert property ($rose(o_running) |-> up_q == SETUP_CYCLES + 1)
    else $error("start-up length wrong");
  oe_run_a: assert property (o_general_output_pin_oe == o_running)
    else $error("serial enable differs from running");
  ready_run_a: assert property (!o_running |-> !o_cs_ready)
    else $error("bits taken before running");
  rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  rd_unmapped_a: assert property (i_reg_rd && i_reg_addr > 8'h30 |=>
    o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  irq_cause_a: assert property (o_xfer_irq |->
    $past(i_block_start) && $past(i_pll_lock)) else $error("stray transfer irq");
  rate_bound_a: assert property ($changed(o_received_rate_field) |->
    $past(i_block_start)) else $error("rate moved off boundary");
  cover property (o_xfer_irq);
  cover property ($rose(o_running));
  cover property (i_block_start && !i_pll_lock);
endmodule

bind csb_channel_status_buffer csb_checker #(.SETUP_CYCLES(SETUP_CYCLES)) csb_checker_inst (
  .i_sys_clk, .i_rstn, .i_block_start, .i_pll_lock, .i_reg_rd, .i_reg_addr,
  .o_reg_rdata, .o_reg_rvalid, .o_running, .o_cs_ready, .o_general_output_pin_oe,
  .o_xfer_irq, .o_received_rate_field);

// *** dv/csb_host.sv ***
module csb_host (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_reg_addr = 8'hff;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd = 1'b0;
  end
  // Idle address and data show the inverse so a stale value never looks meant.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_sys_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask
  // A read takes two cycles, far inside the gap between transfers.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_sys_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_sys_clk);
    // The answer stands for one cycle only, so it is taken inside that cycle.
    d = i_reg_rdata;
    v = i_reg_rvalid;
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
  endtask
endmodule

// *** dv/csb_channel_status_buffer_tb.sv ***
module csb_channel_status_buffer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_cs_valid = 1'b0, i_cs_bit = 1'b0;
  logic i_cs_chan_b = 1'b0, i_block_start = 1'b0, i_pll_lock = 1'b1, fc_run = 1'b1;
  logic i_burst_valid = 1'b0, i_output_frame_clock = 1'b0, uoe = 1'b0;
  logic [3:0] err = 4'h0;
  logic irq_seen = 1'b0, irq_end = 1'b0;
  logic [1:0] i_received_rate_field = 2'h0, o_received_rate_field, exp_rate = 2'h0;
  logic [15:0] i_burst_info_word = 16'h0, i_burst_length_word = 16'h0;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, vis_a, vis_b;
  logic i_reg_wr, i_reg_rd, o_reg_rvalid, o_cs_ready, o_running, o_mode_master;
  logic o_mode_format, o_general_output_pin, o_general_output_pin_oe, o_xfer_irq;
  int n_errors = 0;
  int tests_run = 0;
  initial forever #12.5 i_sys_clk = ~i_sys_clk;
  always @(negedge i_sys_clk) if (fc_run) i_output_frame_clock <= ~i_output_frame_clock;
  csb_channel_status_buffer #(.SETUP_CYCLES(4)) csb_channel_status_buffer_inst (
    .i_sys_clk, .i_rstn, .i_master_slave_strap_pin(1'b1), .i_output_format_strap_pin(1'b0),
    .i_cs_valid, .o_cs_ready, .i_cs_bit, .i_cs_chan_b, .i_block_start, .i_pll_lock,
    .i_err_biphase(err[0]), .i_err_confidence(err[1]), .i_err_parity(err[2]),
    .i_err_crc(err[3]), .i_received_rate_field, .i_burst_valid, .i_burst_info_word,
    .i_burst_length_word, .i_output_frame_clock, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
    .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .o_running, .o_mode_master, .o_mode_format,
    .o_general_output_pin, .o_general_output_pin_oe, .o_xfer_irq, .o_received_rate_field);
  csb_host csb_host_inst (.i_sys_clk, .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid),
    .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr), .o_reg_wdata(i_reg_wdata),
    .o_reg_rd(i_reg_rd));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    csb_host_inst.rd_reg(a, d, v);
    chk("rvalid", 8'h01, {7'h0, v});
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic send1(input logic b, input logic ch);
    int n;
    @(negedge i_sys_clk);
    i_cs_valid = 1'b1;
    i_cs_bit = b;
    i_cs_chan_b = ch;
    for (n = 0; n < 50 && o_cs_ready !== 1'b1; n++) @(negedge i_sys_clk);
    if (n == 50)
      chk("cs_ready", 8'h01, 8'h00);
    @(negedge i_sys_clk);
    i_cs_valid = 1'b0;
    i_cs_bit = ~b;
  endtask
  // The transfer interrupt stands for one cycle, so it is sampled inside that cycle.
  task automatic boundary();
    @(negedge i_sys_clk);
    i_block_start = 1'b1;
    @(negedge i_sys_clk);
    irq_seen = o_xfer_irq;
    i_block_start = 1'b0;
    @(negedge i_sys_clk);
    irq_end = o_xfer_irq;
  endtask
  // One block: bits A and B interleaved, errors at its start, then the boundary.
  task automatic run_blk(input logic [7:0] a, b, input logic [3:0] e, input logic ok);
    @(negedge i_sys_clk);
    err = e;
    i_received_rate_field = a[1:0];
    @(negedge i_sys_clk);
    err = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      send1(a[i], 1'b0);
      send1(b[i], 1'b1);
    end
    boundary();
    chk("irq", {7'h0, ok}, {7'h0, irq_seen});
    chk("irq end", 8'h00, {7'h0, irq_end});
    if (ok)
    begin
      vis_a = a;
      vis_b = b;
    end
    if (!(uoe && e != 4'h0))
      exp_rate = a[1:0];
    chk("rate", {6'h0, exp_rate}, {6'h0, o_received_rate_field});
    rdc(8'h23, vis_a);
    rdc(8'h28, vis_b);
  endtask
  initial
  begin
    repeat (3) @(negedge i_sys_clk);
    chk("reset outs", 8'h00, {4'h0, o_running, o_general_output_pin_oe, o_cs_ready, o_xfer_irq});
    repeat (3) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    for (int i = 0; i < 20 && o_running !== 1'b1; i++) @(negedge i_sys_clk);
    chk("running", 8'h01, {7'h0, o_running});
    chk("mode", 8'h02, {6'h0, o_mode_master, o_mode_format});
    chk("oe", 8'h01, {7'h0, o_general_output_pin_oe});
    rdc(8'h04, 8'h00);
    rdc(8'h10, 8'h00);
    $display("test reset done");
    fc_run = 1'b0;
    send1(1'b1, 1'b0);
    send1(1'b0, 1'b0);
    chk("cs_ready full", 8'h00, {7'h0, o_cs_ready});
    fc_run = 1'b1;
    for (int i = 0; i < 6 && o_general_output_pin !== 1'b1; i++) @(negedge i_sys_clk);
    chk("serial 1st", 8'h01, {7'h0, o_general_output_pin});
    for (int i = 0; i < 6 && o_general_output_pin !== 1'b0; i++) @(negedge i_sys_clk);
    chk("serial 2nd", 8'h00, {7'h0, o_general_output_pin});
    $display("test serial done");
    boundary();
    csb_host_inst.wr_reg(8'h10, 8'h01);
    run_blk(8'ha5, 8'h3c, 4'h0, 1'b1);
    csb_host_inst.wr_reg(8'h04, 8'h04);
    rdc(8'h04, 8'h04);
    run_blk(8'h11, 8'h22, 4'h0, 1'b0);
    csb_host_inst.wr_reg(8'h04, 8'h00);
    run_blk(8'h11, 8'h22, 4'h0, 1'b1);
    run_blk(8'h77, 8'h81, 4'h4, 1'b1);
    csb_host_inst.wr_reg(8'h16, 8'h80);
    uoe = 1'b1;
    for (int k = 0; k < 4; k++) run_blk({6'h18, k[1:0]}, 8'h99, 4'h1 << k, 1'b0);
    i_pll_lock = 1'b0;
    run_blk(8'h55, 8'h56, 4'h0, 1'b0);
    i_pll_lock = 1'b1;
    run_blk(8'h57, 8'h58, 4'h0, 1'b1);
    $display("test buffer done");
    @(negedge i_sys_clk);
    i_burst_info_word = 16'h1234;
    i_burst_length_word = 16'h5678;
    i_burst_valid = 1'b1;
    @(negedge i_sys_clk);
    i_burst_valid = 1'b0;
    i_burst_info_word = 16'hedcb;
    csb_host_inst.wr_reg(8'h2d, 8'hff);
    rdc(8'h2d, 8'h34);
    rdc(8'h2e, 8'h12);
    rdc(8'h2f, 8'h78);
    rdc(8'h30, 8'h56);
    rdc(8'h31, 8'h00);
    $display("test burst done");
    complete_run();
  end
endmodule
